// file: rtl/psm_ctrl.sv
// Power save mode controller: mode decode, clock gating, wake and reset qualification
// Operation
// - Reset starts default run mode, minimal clocks
// - Wake returns to run mode at entry
// - Reset during power save goes default mode
// - I/O configuration held in all power save modes
// - Sleep depth gates clocks level by level
// - Depth gating overrides peripheral clock masks
// - Stopped modules cannot wake from sleep
// - Deep and backup clear selects sleep
// - Sleep on ISR exit also enters
// - Unmasked priority interrupt ends sleep
// - Wait and retention keep core, slow clocks
// - Deep select, no backup: wait or retention
// - Async wake needs peripheral and enable bit; sources 0 and 1 need no enable bit
// - Async wake raises wake interrupt with cause
// - Backup powers off core, keeps backup domain
// - Deep and backup selects enter backup
// - Brownouts, watchdog, pin reset exit backup
// - Listed wake events exit backup
// - Slow clock select picks backup oscillator
// - Reset exit records source at once, releases core after stable supply
// - Wake exit resets core only, previous mode
// - Wake exit sets backup flag and cause
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module psm_ctrl
  import psm_pkg::*;
#(
  parameter int unsigned NPERIPH = 8,
  parameter int unsigned RUN_W = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire psm_pkg::psm_bus_s bus,
  output logic [psm_pkg::DATA_W-1:0] rdata,
  input wire logic wfi_exec,
  input wire logic isr_exit_lowest,
  input wire logic deep_sleep_select,
  input wire logic sleep_on_isr_exit,
  input wire logic irq_pending,
  input wire logic [NPERIPH-1:0] periph_irq_on_ahb,
  input wire logic [NPERIPH-1:0] periph_irq_on_apb,
  input wire logic [NPERIPH-1:0] periph_clk_mask,
  input wire logic [psm_pkg::NSRC-1:0] async_wake_req,
  input wire logic [6:0] backup_wake_req,
  input wire logic [3:0] reset_req,
  input wire logic core_supply_ok,
  output psm_pkg::psm_clk_s clk_en,
  output logic [NPERIPH-1:0] periph_clk_en,
  output logic core_power_on,
  output logic core_reset_n,
  output logic io_hold,
  output logic slow_clock_select,
  output logic wake_irq,
  output logic [RUN_W-1:0] run_mode,
  output logic cpu_halted
);

  initial begin
    if (NPERIPH < 1) $error("psm_ctrl: NPERIPH must be at least one");
    if (RUN_W < 1 || RUN_W > 8) $error("psm_ctrl: RUN_W must be 1 to 8");
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [NSRC-1:0] async_wake_s;
  logic [6:0] bk_wake_s;
  logic [3:0] rst_req_s;
  logic supply_ok_s;

  psm_sync #(.W(NSRC + 12)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d({async_wake_req, backup_wake_req, reset_req, core_supply_ok}),
    .q({async_wake_s, bk_wake_s, rst_req_s, supply_ok_s})
  );

  // ************************************************************
  // Registers
  // ************************************************************
  logic [DATA_W-1:0] control;
  logic [NSRC-1:0] async_wake_enable;
  logic [7:0] wake_cause;
  logic [6:0] backup_wake_cause;
  logic [3:0] reset_cause;
  logic backup_flag;
  psm_state_e state;
  psm_state_e next_state;
  logic [RUN_W-1:0] saved_run;
  logic [$clog2(CORE_RST_CYC+1)-1:0] hold_cnt;
  logic exit_by_reset;

  logic [1:0] sleep_depth_field;
  logic retention_select;
  logic backup_select;
  logic wake_irq_enable;
  assign sleep_depth_field = control[BIT_DEPTH_LO +: 2];
  assign retention_select = control[BIT_RETENTION];
  assign backup_select = control[BIT_BACKUP];
  assign wake_irq_enable = control[BIT_WAKE_IRQ_EN];

  logic any_reset;
  logic [NSRC-1:0] async_hits;
  logic [6:0] bk_hits;
  logic entry;
  logic sleep_wake;
  logic write_control;
  assign any_reset = |rst_req_s;
  assign async_hits = async_wake_s & (async_wake_enable | AWAKE_ALWAYS);
  assign bk_hits = bk_wake_s;
  assign entry = wfi_exec | (sleep_on_isr_exit & isr_exit_lowest);
  assign write_control = bus.wr && bus.addr == OFS_CONTROL;

  // Only interrupts from modules still clocked count
  logic [NPERIPH-1:0] live_irq;
  always_comb begin
    live_irq = '0;
    case (sleep_depth_field)
      PSM_DEPTH_CPU: live_irq = periph_irq_on_ahb | periph_irq_on_apb;
      PSM_DEPTH_AHB: live_irq = periph_irq_on_apb;
      default: live_irq = '0;
    endcase
  end
  assign sleep_wake = irq_pending && ((sleep_depth_field == PSM_DEPTH_CPU) || (|live_irq));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      control <= CONTROL_RESET;
    end else if (write_control) begin
      control <= bus.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      async_wake_enable <= '0;
    end else if (bus.wr && bus.addr == OFS_ASYNC_WAKE_ENABLE) begin
      async_wake_enable <= bus.wdata[NSRC-1:0];
    end
  end

  // ************************************************************
  // Mode sequencer
  // ************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (entry) begin
          if (!deep_sleep_select) begin
            next_state = ST_SLEEP;
          end else if (backup_select) begin
            next_state = ST_BACKUP;
          end else if (retention_select) begin
            next_state = ST_RETAIN;
          end else begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_SLEEP: begin
        if (sleep_wake) begin
          next_state = ST_RUN;
        end
      end
      ST_WAIT, ST_RETAIN: begin
        if (|async_hits) begin
          next_state = ST_RUN;
        end
      end
      ST_BACKUP: begin
        if (any_reset || (|bk_hits)) begin
          next_state = ST_CORE_RESET;
        end
      end
      ST_CORE_RESET: begin
        if (supply_ok_s && hold_cnt == CORE_RST_CYC[$bits(hold_cnt)-1:0]) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RUN;
    end else if (any_reset && state != ST_BACKUP && state != ST_CORE_RESET) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // The run mode field of the control register is saved at entry; run_mode holds the current mode
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      saved_run <= '0;
    end else if (state == ST_RUN && entry) begin
      saved_run <= control[BIT_RUN_LO +: RUN_W];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run_mode <= '0;
    end else if (any_reset) begin
      run_mode <= '0;
    end else if (state == ST_CORE_RESET && exit_by_reset) begin
      run_mode <= '0;
    end else if (state != ST_RUN && next_state == ST_RUN) begin
      run_mode <= saved_run;
    end else if (state == ST_RUN && write_control) begin
      run_mode <= bus.wdata[BIT_RUN_LO +: RUN_W];
    end
  end

  // Reset wins over a wake seen in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      exit_by_reset <= 1'b0;
    end else if (state == ST_BACKUP && any_reset) begin
      exit_by_reset <= 1'b1;
    end else if (state == ST_BACKUP && |bk_hits) begin
      exit_by_reset <= 1'b0;
    end else if (state == ST_CORE_RESET && any_reset) begin
      exit_by_reset <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt <= '0;
    end else if (state != ST_CORE_RESET || !supply_ok_s) begin
      hold_cnt <= '0;
    end else if (hold_cnt != CORE_RST_CYC[$bits(hold_cnt)-1:0]) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // ************************************************************
  // Cause recording
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_cause <= '0;
    end else if ((state == ST_WAIT || state == ST_RETAIN) && |async_hits) begin
      wake_cause <= wake_cause | async_hits;
    end else if (bus.wr && bus.addr == OFS_CAUSES) begin
      wake_cause <= wake_cause & ~bus.wdata[BIT_WAKE_CAUSE_LO +: NSRC];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= wake_irq_enable && (|wake_cause);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reset_cause <= '0;
      backup_flag <= 1'b0;
      backup_wake_cause <= '0;
    end else if (state == ST_BACKUP && any_reset) begin
      reset_cause <= rst_req_s;
      backup_flag <= 1'b0;
    end else if (state == ST_BACKUP && |bk_hits) begin
      backup_flag <= 1'b1;
      backup_wake_cause <= bk_hits;
    end else if (any_reset) begin
      reset_cause <= rst_req_s;
    end
  end

  // ************************************************************
  // Clock, power and pin outputs
  // ************************************************************
  logic in_low;
  logic slow_clk_pick;
  assign in_low = state == ST_WAIT || state == ST_RETAIN || state == ST_BACKUP || state == ST_CORE_RESET;
  assign slow_clk_pick = control[BIT_SLOW_CLK];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_en <= '{cpu: 1'b1, ahb: 1'b1, apb_gen: 1'b1, fast_src: 1'b0, sys_rc: 1'b1,
                  xtal_slow: 1'b0, rc_slow: 1'b0};
    end else begin
      clk_en.cpu <= state == ST_RUN;
      clk_en.ahb <= state == ST_RUN || (state == ST_SLEEP && sleep_depth_field == PSM_DEPTH_CPU);
      clk_en.apb_gen <= state == ST_RUN || (state == ST_SLEEP && sleep_depth_field < PSM_DEPTH_APB);
      clk_en.fast_src <= state == ST_RUN || (state == ST_SLEEP && sleep_depth_field != PSM_DEPTH_SRC);
      clk_en.sys_rc <= !in_low;
      clk_en.xtal_slow <= control[BIT_XTAL_EN];
      clk_en.rc_slow <= control[BIT_RCSLOW_EN];
    end
  end

  // Depth gating overrides the per-module mask
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      periph_clk_en <= '0;
    end else if (state == ST_RUN || (state == ST_SLEEP && sleep_depth_field < PSM_DEPTH_APB)) begin
      periph_clk_en <= periph_clk_mask;
    end else begin
      periph_clk_en <= '0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      core_power_on <= 1'b1;
      core_reset_n <= 1'b1;
      io_hold <= 1'b0;
      slow_clock_select <= 1'b0;
      cpu_halted <= 1'b0;
    end else begin
      core_power_on <= state != ST_BACKUP;
      core_reset_n <= !(state == ST_BACKUP || state == ST_CORE_RESET);
      io_hold <= state != ST_RUN;
      slow_clock_select <= slow_clk_pick;
      cpu_halted <= state != ST_RUN;
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_CONTROL: rdata <= control;
        OFS_ASYNC_WAKE_ENABLE: rdata <= {{(DATA_W-NSRC){1'b0}}, async_wake_enable};
        OFS_STATUS: rdata <= {{(DATA_W-8-RUN_W){1'b0}}, run_mode, 5'h00, state == ST_RUN, state == ST_SLEEP,
                              core_power_on};
        OFS_CAUSES: rdata <= {7'h00, backup_flag, 4'h0, reset_cause, 1'b0, backup_wake_cause, wake_cause};
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule

// file: rtl/psm_pkg.sv
// Package for the power save mode controller: register map, fields, states and timing
package psm_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NSRC = 8;

  // Register offsets (byte addresses, one word each)
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_ASYNC_WAKE_ENABLE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CAUSES = 4'hC;

  // Control register fields
  localparam int unsigned BIT_DEPTH_LO = 0;
  localparam int unsigned BIT_RETENTION = 2;
  localparam int unsigned BIT_BACKUP = 3;
  localparam int unsigned BIT_SLOW_CLK = 4;
  localparam int unsigned BIT_XTAL_EN = 5;
  localparam int unsigned BIT_RCSLOW_EN = 6;
  localparam int unsigned BIT_WAKE_IRQ_EN = 7;
  localparam int unsigned BIT_RUN_LO = 8;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 32'h0000_0000;

  // Cause register fields
  localparam int unsigned BIT_WAKE_CAUSE_LO = 0;
  localparam int unsigned BIT_BACKUP_SELECT_WAKE_CAUSE_LO = 8;
  localparam int unsigned BIT_RESET_CAUSE_LO = 16;
  localparam int unsigned BIT_BACKUP_SELECT_FLAG = 24;

  // Backup wake source positions
  localparam int unsigned WK_EXT_IRQ = 0;
  localparam int unsigned WK_ASUP_BOD = 1;
  localparam int unsigned WK_CSUP_BOD = 2;
  localparam int unsigned WK_CAL_ALARM = 3;
  localparam int unsigned WK_CAL_PERIOD = 4;
  localparam int unsigned WK_CAL_OVF = 5;
  localparam int unsigned WK_WDOG = 6;

  // Reset source positions
  localparam int unsigned RS_ASUP_BOD = 0;
  localparam int unsigned RS_CSUP_BOD = 1;
  localparam int unsigned RS_WDOG = 2;
  localparam int unsigned RS_PIN = 3;

  // Asynchronous wake sources that need no enable bit
  localparam logic [NSRC-1:0] AWAKE_ALWAYS = 8'h03;

  // Core reset hold after supply is stable
  localparam int unsigned CORE_RST_HOLD_NS = 200;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned CORE_RST_CYC = (CORE_RST_HOLD_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    PSM_DEPTH_CPU,
    PSM_DEPTH_AHB,
    PSM_DEPTH_APB,
    PSM_DEPTH_SRC
  } psm_depth_e;

  typedef enum {
    ST_RUN,
    ST_SLEEP,
    ST_WAIT,
    ST_RETAIN,
    ST_BACKUP,
    ST_CORE_RESET
  } psm_state_e;

  typedef struct packed {
    logic cpu;
    logic ahb;
    logic apb_gen;
    logic fast_src;
    logic sys_rc;
    logic xtal_slow;
    logic rc_slow;
  } psm_clk_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } psm_bus_s;

endpackage

// file: rtl/psm_sync.sv
// Two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module psm_sync #(
  parameter int unsigned W = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  initial begin
    if (W < 1) $error("psm_sync: width must be at least one");
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: tb/psm_ctrl_properties.sv
// Concurrent checks on the ports of the power save mode controller
`timescale 1ns/1ps
module psm_ctrl_chk
  import psm_pkg::*;
#(
  parameter int unsigned NPERIPH = 8,
  parameter int unsigned RUN_W = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wfi_exec,
  input wire logic deep_sleep_select,
  input wire logic irq_pending,
  input wire logic [3:0] reset_req,
  input wire logic core_supply_ok,
  input wire psm_pkg::psm_clk_s clk_en,
  input wire logic [NPERIPH-1:0] periph_clk_en,
  input wire logic core_power_on,
  input wire logic core_reset_n,
  input wire logic io_hold,
  input wire logic [RUN_W-1:0] run_mode,
  input wire logic cpu_halted
);
  int ok_cnt;
  // Saturates so a long stable supply never wraps back below the hold
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ok_cnt <= 0;
    end else begin
      ok_cnt <= !core_supply_ok ? 0 : (ok_cnt < 1000 ? ok_cnt + 1 : ok_cnt);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_sleep_req;
    !cpu_halted && core_reset_n && core_power_on && wfi_exec && !deep_sleep_select;
  endsequence
  sequence s_light_sleep_irq;
    cpu_halted && clk_en.ahb && irq_pending;
  endsequence
  AST_SLEEP_ENTRY: assert property (s_sleep_req |-> ##2 (cpu_halted && !clk_en.cpu))
    else $error("sleep not entered");
  AST_SLEEP_WAKE: assert property (s_light_sleep_irq |-> ##[1:3] !cpu_halted)
    else $error("sleep not left on interrupt");
  AST_DEPTH_NEST: assert property ((!clk_en.apb_gen |-> !clk_en.ahb) and (!clk_en.ahb |-> !clk_en.cpu))
    else $error("clock stop order broken");
  AST_MASK_OVERRIDE: assert property (!clk_en.apb_gen |-> periph_clk_en == '0)
    else $error("peripheral clock left running");
  AST_IO_HELD: assert property ((cpu_halted || !core_power_on) |-> io_hold)
    else $error("io not held");
  AST_BACKUP_CLOCKS: assert property (!core_power_on |-> (clk_en & 7'h7C) == 7'h00)
    else $error("fast clock running while core unpowered");
  AST_CORE_RST_HOLD: assert property ($rose(core_reset_n) |-> ok_cnt >= CORE_RST_CYC)
    else $error("core reset released early");
  AST_RESET_TO_DEFAULT: assert property ($rose(|reset_req) |-> ##[2:40] run_mode == '0)
    else $error("reset did not restore default run mode");
endmodule

// file: tb/psm_far.sv
// Model of the core supply regulator and of the wake and reset sources
`timescale 1ns/1ps
module psm_far (
  input wire logic ref_clk,
  input wire logic core_power_on,
  output logic core_supply_ok,
  output logic [7:0] async_wake_req,
  output logic [6:0] backup_wake_req,
  output logic [3:0] reset_req
);
  int ramp = 4;
  int cnt = 0;
  initial begin
    core_supply_ok = 1'h1;
    async_wake_req = 8'h00;
    backup_wake_req = 7'h00;
    reset_req = 4'h0;
  end
  // Supply sags at once when the core is unpowered, then needs ramp cycles
  always @(posedge ref_clk) begin
    if (core_power_on !== 1'h1) begin
      cnt <= 0;
      core_supply_ok <= 1'h0;
    end else if (cnt < ramp) begin
      cnt <= cnt + 1;
    end else begin
      core_supply_ok <= 1'h1;
    end
  end
  // Levels held long enough to cross the two-flop synchroniser
  task automatic fire(input logic [7:0] a, input logic [6:0] b, input logic [3:0] r);
    async_wake_req <= a;
    backup_wake_req <= b;
    reset_req <= r;
    repeat (6) @(posedge ref_clk);
    async_wake_req <= 8'h00;
    backup_wake_req <= 7'h00;
    reset_req <= 4'h0;
  endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the power save mode controller
`timescale 1ns/1ps
module tb;
  import psm_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    logic isr;
    logic [6:0] clk;
    logic [1:0] wake;
    logic [1:0] run;
  } psm_row_s;
  logic ref_clk, resetn, wfi_exec, isr_exit_lowest, deep_sleep_select, sleep_on_isr_exit, irq_pending;
  logic core_supply_ok, core_power_on, core_reset_n, io_hold, slow_clock_select, wake_irq, cpu_halted;
  logic [7:0] ahb_irq, apb_irq, periph_clk_mask, periph_clk_en, async_wake_req;
  logic [6:0] backup_wake_req;
  logic [3:0] reset_req;
  logic [1:0] run_mode;
  logic [31:0] rdata, d;
  psm_bus_s bus;
  psm_clk_s clk_en;
  int err_total, num_checks;
  int cyc = 0;
  // Depth 2 and 3 rows leave by reset since no clocked source can wake them
  psm_row_s rows [4] = '{
    '{32'h0000_0220, 1'h0, 7'h3E, 2'h0, 2'h2},
    '{32'h0000_0141, 1'h1, 7'h1D, 2'h1, 2'h1},
    '{32'h0000_0302, 1'h0, 7'h0C, 2'h2, 2'h3},
    '{32'h0000_0163, 1'h1, 7'h07, 2'h2, 2'h1}};
  psm_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .rdata(rdata), .wfi_exec(wfi_exec),
    .isr_exit_lowest(isr_exit_lowest), .deep_sleep_select(deep_sleep_select),
    .sleep_on_isr_exit(sleep_on_isr_exit), .irq_pending(irq_pending), .periph_irq_on_ahb(ahb_irq),
    .periph_irq_on_apb(apb_irq), .periph_clk_mask(periph_clk_mask), .async_wake_req(async_wake_req),
    .backup_wake_req(backup_wake_req), .reset_req(reset_req), .core_supply_ok(core_supply_ok),
    .clk_en(clk_en), .periph_clk_en(periph_clk_en), .core_power_on(core_power_on),
    .core_reset_n(core_reset_n), .io_hold(io_hold), .slow_clock_select(slow_clock_select),
    .wake_irq(wake_irq), .run_mode(run_mode), .cpu_halted(cpu_halted));
  psm_far far (.ref_clk(ref_clk), .core_power_on(core_power_on), .core_supply_ok(core_supply_ok),
    .async_wake_req(async_wake_req), .backup_wake_req(backup_wake_req), .reset_req(reset_req));
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'h1;
    @(posedge ref_clk);
    bus.wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    bus.addr <= a;
    bus.rd <= 1'h1;
    @(posedge ref_clk);
    bus.rd <= 1'h0;
    #1 d = rdata;
    @(posedge ref_clk);
  endtask
  task automatic enter(input logic deep, input logic isr);
    deep_sleep_select <= deep;
    sleep_on_isr_exit <= isr;
    if (isr) isr_exit_lowest <= 1'h1;
    else wfi_exec <= 1'h1;
    @(posedge ref_clk);
    wfi_exec <= 1'h0;
    isr_exit_lowest <= 1'h0;
  endtask
  // Leaves one time unit after an edge, so the caller realigns before driving
  task automatic wait_until(input int sel, input logic v);
    logic s;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 s = sel == 0 ? cpu_halted : (sel == 1 ? core_reset_n : core_power_on);
      n++;
    end while (s !== v && n < 80);
    chk(s, v);
  endtask
  initial begin
    resetn = 1'h0;
    bus = '0;
    wfi_exec = 1'h0;
    isr_exit_lowest = 1'h0;
    deep_sleep_select = 1'h0;
    sleep_on_isr_exit = 1'h0;
    irq_pending = 1'h0;
    ahb_irq = 8'h00;
    apb_irq = 8'h00;
    periph_clk_mask = 8'hFF;
    err_total = 0;
    num_checks = 0;
    repeat (5) @(posedge ref_clk);
    #1 chk(clk_en, 7'h74);
    chk(run_mode, 2'h0);
    @(posedge ref_clk);
    resetn <= 1'h1;
    @(posedge ref_clk);
    rd(OFS_CONTROL);
    chk(d, CONTROL_RESET);
    rd(4'h2);
    chk(d, 32'h0000_0000);
    rd(OFS_STATUS);
    chk(d, 32'h0000_0005);
    foreach (rows[i]) begin
      wr(OFS_CONTROL, rows[i].ctrl);
      enter(1'h0, rows[i].isr);
      wait_until(0, 1'h1);
      chk(clk_en, rows[i].clk);
      if (rows[i].ctrl[1]) chk(periph_clk_en, 8'h00);
      rd(OFS_STATUS);
      chk(d, {22'h0, rows[i].run, 8'h03});
      @(posedge ref_clk);
      irq_pending <= 1'h1;
      ahb_irq <= 8'h01;
      if (rows[i].wake != 2'h0) begin
        repeat (6) @(posedge ref_clk);
        #1 chk(cpu_halted, 1'h1);
        @(posedge ref_clk);
        apb_irq <= 8'h01;
        if (rows[i].wake == 2'h2) far.fire(8'h00, 7'h00, 4'h8);
      end
      wait_until(0, 1'h0);
      chk(run_mode, rows[i].wake == 2'h2 ? 2'h0 : rows[i].run);
      @(posedge ref_clk);
      irq_pending <= 1'h0;
      ahb_irq <= 8'h00;
      apb_irq <= 8'h00;
      rd(OFS_CAUSES);
      if (rows[i].wake == 2'h2) chk(d[BIT_RESET_CAUSE_LO + RS_PIN], 1'h1);
    end
    wr(OFS_ASYNC_WAKE_ENABLE, 32'h0000_0004);
    for (int r = 0; r < 2; r++) begin
      wr(OFS_CONTROL, 32'h0000_00A0 | (r << BIT_RETENTION));
      enter(1'h1, 1'h0);
      wait_until(0, 1'h1);
      chk(clk_en, 7'h02);
      chk(core_power_on, 1'h1);
      @(posedge ref_clk);
      far.fire(8'h08, 7'h00, 4'h0);
      #1 chk(cpu_halted, 1'h1);
      @(posedge ref_clk);
      // Retention is woken here by source 0, which needs no enable bit; wait by enabled source 2
      far.fire(r ? 8'h01 : 8'h04, 7'h00, 4'h0);
      wait_until(0, 1'h0);
      chk(wake_irq, 1'h1);
      @(posedge ref_clk);
      rd(OFS_CAUSES);
      chk(d[7:0], r ? 8'h01 : 8'h04);
      wr(OFS_CAUSES, 32'h0000_00FF);
    end
    for (int k = 0; k < 2; k++) begin
      far.ramp = 4 + 12 * k;
      wr(OFS_CONTROL, 32'h0000_0158);
      enter(1'h1, 1'h0);
      wait_until(2, 1'h0);
      chk(clk_en, 7'h01);
      chk(slow_clock_select, 1'h1);
      chk(io_hold, 1'h1);
      @(posedge ref_clk);
      far.fire(8'h00, k ? 7'h01 : 7'h08, k ? 4'h4 : 4'h0);
      wait_until(1, 1'h1);
      chk(run_mode, k ? 2'h0 : 2'h1);
      @(posedge ref_clk);
      rd(OFS_CAUSES);
      chk(d[BIT_BACKUP_SELECT_FLAG], k ? 1'h0 : 1'h1);
      if (k) chk(d[BIT_RESET_CAUSE_LO + RS_WDOG], 1'h1);
      else chk(d[14:8], 7'h08);
    end
    close_out();
  end
endmodule
bind psm_ctrl psm_ctrl_chk #(.NPERIPH(NPERIPH), .RUN_W(RUN_W)) u_chk (.ref_clk(ref_clk), .resetn(resetn),
  .wfi_exec(wfi_exec), .deep_sleep_select(deep_sleep_select), .irq_pending(irq_pending),
  .reset_req(reset_req), .core_supply_ok(core_supply_ok), .clk_en(clk_en), .periph_clk_en(periph_clk_en),
  .core_power_on(core_power_on), .core_reset_n(core_reset_n), .io_hold(io_hold), .run_mode(run_mode),
  .cpu_halted(cpu_halted));
